// >>> verilog/fbewm_defs.vh
// Constants for the fieldbus error and warning monitor
`ifndef FBEWM_DEFS_VH
`define FBEWM_DEFS_VH

// Register byte offsets (word aligned)
`define FBEWM_REG_CTRL       8'h00
`define FBEWM_REG_STATUS     8'h04
`define FBEWM_REG_WARN_NOW   8'h08
`define FBEWM_REG_HIST_CNT   8'h0C

// History window starts here; entry k is at base + 4*k, k = 0 is newest
`define FBEWM_REG_HIST_BASE  8'h40
// Top two address bits that select the history window
`define FBEWM_HIST_SEL       2'h1

// Control register bits
`define FBEWM_CTRL_HIST_CLR  0
`define FBEWM_CTRL_ERR_CLR   1

// Status register bits
`define FBEWM_ST_LINK_RUN    0
`define FBEWM_ST_LINK_ERR    1
`define FBEWM_ST_ERR_BLINK   2
`define FBEWM_ST_WARN        3
`define FBEWM_ST_MOTOR_STOP  4
`define FBEWM_ST_BAD_SWITCH  5
`define FBEWM_ST_SW_CHANGED  6

// Warning codes
`define FBEWM_WCODE_NONE     8'h00
`define FBEWM_WCODE_SERIAL   8'h84
`define FBEWM_WCODE_TIMEOUT  8'h85

// Switch limits
`define FBEWM_BAUD_MAX       3'h4
`define FBEWM_STATION_MIN    7'h01
`define FBEWM_STATION_MAX    7'h40

// History depth
`define FBEWM_HIST_DEPTH     10

// Blink half period in ns and the derived cycle count at 40 MHz
`define FBEWM_CLK_HZ         40000000
`define FBEWM_BLINK_HALF_NS  250000000
`define FBEWM_BLINK_CYCLES   ((`FBEWM_BLINK_HALF_NS / 1000) * (`FBEWM_CLK_HZ / 1000000))

`endif

// >>> verilog/fbewm_hist_mem.v
// Small register file holding the warning history entries
`timescale 1ns/10ps
`default_nettype none

module fbewm_hist_mem #(
    parameter DEPTH = 10,
    parameter AW    = 4
) (
    // Clock
    input  wire         clk,
    // Write port
    input  wire         wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [7:0]   wr_data,
    // Read port, registered data
    input  wire [AW-1:0] rd_addr,
    output reg  [7:0]   rd_data
);

    // Storage has no reset: contents only mean something under the count
    reg [7:0] mem [0:DEPTH-1];

    // Write and registered read
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule // fbewm_hist_mem

`default_nettype wire

// >>> verilog/fbewm_blink.v
// Free running blink generator for the link error indicator
`timescale 1ns/10ps
`default_nettype none

module fbewm_blink #(
    parameter HALF_CYCLES = 10000000
) (
    // Clock and reset
    input  wire clk,
    input  wire sys_rst,
    // Square wave out
    output reg  blink
);

    // Cycle counter for one half period
    reg [31:0] count;

    // Toggle each half period
    always @(posedge clk) begin
        if (sys_rst) begin
            count <= 32'h00000000;
            blink <= 1'b0;
        end else if (count >= HALF_CYCLES - 1) begin
            count <= 32'h00000000;
            blink <= ~blink;
        end else begin
            count <= count + 32'h00000001;
        end
    end

endmodule // fbewm_blink

`default_nettype wire

// >>> verilog/fbewm_monitor.v
// Fieldbus error and warning monitor with Avalon-MM register access
//
// How it works
// [RULE1] Stop motor on link error or halt
// [RULE2] Run lamp off when master stops link
// [RULE3] Run lamp off on duplicate station number
// [RULE4] Bad switch values: run off, error lit
// [RULE5] Switch change at run: error blinks, ignored
// [RULE6] Warning sets output bit, motor continues
// [RULE7] Warning clears itself when cause ends
// [RULE8] Ten newest codes kept, newest first
// [RULE9] History in volatile storage only
// [RULE10] Serial bus error gives code 84h
// [RULE11] Serial response timeout gives code 85h
// [RULE12] Present code readable by serial, tools
// [RULE13] None gives 00h; else latest raised
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "fbewm_defs.vh"

module fbewm_monitor #(
    parameter HIST_DEPTH   = `FBEWM_HIST_DEPTH,
    parameter BLINK_CYCLES = `FBEWM_BLINK_CYCLES
) (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Setting switches
    input  wire [2:0]  baud_switch,
    input  wire [6:0]  station_switch,
    // Fieldbus conditions
    input  wire        link_stopped,
    input  wire        station_duplicate,
    input  wire        link_fault,
    input  wire        master_halted,
    input  wire        motor_running,
    // Serial bus warning causes, held as levels while present
    input  wire        serial_error,
    input  wire        serial_timeout,
    // Indicator and control outputs
    output reg         link_run_led,
    output reg         link_err_led,
    output reg         motor_stop,
    output reg         warning_output_bit,
    output reg  [7:0]  present_warning,
    // Avalon-MM slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest
);

    // Sampled settings and status
    reg        started;        // Power-up sampling done
    reg [2:0]  baud_held;      // Setting in force until next power cycle
    reg [6:0]  station_held;
    reg        bad_switch;     // Out of range at power-up
    reg        sw_changed;     // Changed during operation
    reg        serial_err_q;   // Previous cause levels for edge detect
    reg        timeout_q;
    reg        err_order;      // 1: serial error raised after timeout
    reg [3:0]  hist_cnt;
    reg [3:0]  hist_head;      // Slot of the newest entry
    reg        rd_pending;     // Read answered one cycle late
    reg        rd_hist;        // Pending read is from history
    reg [31:0] rd_word;
    wire       blink;
    wire [7:0] hist_q;
    reg  [3:0] hist_rd_addr;
    reg  [3:0] next_head;
    reg        hist_wr;
    reg  [7:0] hist_wdata;
    reg  [3:0] hist_rd_hold;   // Slot of the last history read, kept so the answer stands
    reg [31:0] rd_latch;       // Register word captured when a read is taken
    reg        tmo_defer;      // Second half of a same-cycle double raise
    wire       rd_take;        // Read accepted on this edge
    wire       ser_rise;       // Serial error newly raised
    wire       tmo_rise;       // Timeout newly raised
    wire       hist_clr;       // Software asks to empty the history

    // Range check used only at power-up sampling; later compares only look for a change
    function sw_ok;
        input [2:0] b;
        input [6:0] s;
        begin
            sw_ok = (b <= `FBEWM_BAUD_MAX) && (s >= `FBEWM_STATION_MIN) && (s <= `FBEWM_STATION_MAX);
        end
    endfunction

    // Ring index wrap
    function [3:0] wrap;
        input [4:0] v;
        begin
            wrap = (v >= HIST_DEPTH) ? v[3:0] - HIST_DEPTH[3:0] : v[3:0];
        end
    endfunction

    // Blink source for the error lamp
    fbewm_blink #(
        .HALF_CYCLES (BLINK_CYCLES)
    ) u_blink (
        .clk     (clk),
        .sys_rst (sys_rst),
        .blink   (blink)
    );

    // Rising edges of the warning causes; the level flops reset low like idle pins
    assign ser_rise = serial_error && !serial_err_q;
    assign tmo_rise = serial_timeout && !timeout_q;

    // Clear request decoded once for the ring logic
    assign hist_clr = avs_write && (avs_address == `FBEWM_REG_CTRL) && avs_writedata[`FBEWM_CTRL_HIST_CLR];

    // Settings captured once after reset release, then only compared
    always @(posedge clk) begin
        if (sys_rst) begin
            started      <= 1'b0;
            baud_held    <= 3'h0;
            station_held <= 7'h00;
            bad_switch   <= 1'b0;
            sw_changed   <= 1'b0;
        end else if (!started) begin
            started      <= 1'b1;
            baud_held    <= baud_switch;
            station_held <= station_switch;
            bad_switch   <= !sw_ok(baud_switch, station_switch); // RULE4
        end else if ((baud_switch != baud_held) || (station_switch != station_held)) begin
            sw_changed   <= 1'b1; // RULE5
        end
    end

    // Lamps and motor stop; run lamp needs a good, healthy link
    always @(posedge clk) begin
        if (sys_rst) begin
            link_run_led <= 1'b0;
            link_err_led <= 1'b0;
            motor_stop   <= 1'b1;
        end else begin
            link_run_led <= started && !bad_switch && !link_stopped // RULE2
                            && !station_duplicate && !link_fault;     // RULE3
            if (sw_changed) begin
                link_err_led <= blink;      // RULE5
            end else begin
                link_err_led <= bad_switch; // RULE4
            end
            // Warnings are not part of this term, so drives keep running
            motor_stop <= !started || bad_switch || link_stopped || station_duplicate
                          || link_fault || (master_halted && motor_running) || sw_changed; // RULE1
        end
    end

    // Warning levels; bit and code follow causes with no clear command
    always @(posedge clk) begin
        if (sys_rst) begin
            serial_err_q       <= 1'b0;
            timeout_q          <= 1'b0;
            err_order          <= 1'b0;
            tmo_defer          <= 1'b0;
            warning_output_bit <= 1'b0;
            present_warning    <= `FBEWM_WCODE_NONE;
        end else begin
            serial_err_q <= serial_error;
            timeout_q    <= serial_timeout;
            // Timeout first, so a tie keeps the timeout as the latest here too
            if (tmo_rise) begin
                err_order <= 1'b0;
            end else if (ser_rise) begin
                err_order <= 1'b1;
            end
            tmo_defer          <= ser_rise && tmo_rise;
            warning_output_bit <= serial_error || serial_timeout; // RULE6 RULE7
            if (serial_error && serial_timeout) begin
                // Latest raised wins; a tie goes to the timeout
                if (tmo_rise) begin
                    present_warning <= `FBEWM_WCODE_TIMEOUT; // RULE13
                end else if (ser_rise) begin
                    present_warning <= `FBEWM_WCODE_SERIAL; // RULE13
                end else begin
                    present_warning <= err_order ? `FBEWM_WCODE_SERIAL : `FBEWM_WCODE_TIMEOUT;
                end
            end else if (serial_error) begin
                present_warning <= `FBEWM_WCODE_SERIAL; // RULE10
            end else if (serial_timeout) begin
                present_warning <= `FBEWM_WCODE_TIMEOUT; // RULE11
            end else begin
                present_warning <= `FBEWM_WCODE_NONE; // RULE7 RULE13
            end
        end
    end

    // History write on each newly raised warning; one port, so a tie takes two cycles
    always @* begin
        hist_wr    = 1'b0;
        hist_wdata = `FBEWM_WCODE_NONE;
        next_head  = wrap({1'b0, hist_head} + 5'h01);
        if (tmo_defer) begin
            // Neither cause can rise again here, so the late entry never collides
            hist_wr    = 1'b1;
            hist_wdata = `FBEWM_WCODE_TIMEOUT;
        end else if (ser_rise) begin
            // On a tie the serial error goes in first and the timeout lands newest
            hist_wr    = 1'b1;
            hist_wdata = `FBEWM_WCODE_SERIAL;
        end else if (tmo_rise) begin
            hist_wr    = 1'b1;
            hist_wdata = `FBEWM_WCODE_TIMEOUT;
        end
    end

    // Ring pointer and fill count; a clear with a new entry keeps only the new entry
    always @(posedge clk) begin
        if (sys_rst) begin
            hist_head <= 4'h0;
            hist_cnt  <= 4'h0; // RULE9
        end else if (hist_wr) begin
            hist_head <= next_head; // RULE8
            if (hist_clr) begin
                hist_cnt <= 4'h1;
            end else if (hist_cnt < HIST_DEPTH) begin
                hist_cnt <= hist_cnt + 4'h1;
            end
        end else if (hist_clr) begin
            hist_cnt <= 4'h0; // RULE8
        end
    end

    // Entry k back from newest; between reads the last slot is held so the answer stands
    always @* begin
        if (rd_take) begin
            if (avs_address[5:2] < HIST_DEPTH) begin
                hist_rd_addr = wrap({1'b0, hist_head} + HIST_DEPTH[4:0] - {1'b0, avs_address[5:2]}); // RULE8
            end else begin
                // Past the depth: keep the memory address in range, the answer is zero anyway
                hist_rd_addr = 4'h0;
            end
        end else begin
            hist_rd_addr = hist_rd_hold;
        end
    end

    // History storage, volatile
    fbewm_hist_mem #(
        .DEPTH (HIST_DEPTH),
        .AW    (4)
    ) u_hist (
        .clk     (clk),
        .wr_en   (hist_wr),
        .wr_addr (next_head),
        .wr_data (hist_wdata),
        .rd_addr (hist_rd_addr),
        .rd_data (hist_q)
    );

    // Writes complete at once; reads wait one cycle for registered data
    assign rd_take         = avs_read && !rd_pending;
    assign avs_waitrequest = rd_take;

    // Register read mux
    always @* begin
        rd_word = 32'h00000000;
        case (avs_address)
            `FBEWM_REG_STATUS: begin
                rd_word[`FBEWM_ST_LINK_RUN]   = link_run_led;
                rd_word[`FBEWM_ST_LINK_ERR]   = link_err_led;
                rd_word[`FBEWM_ST_ERR_BLINK]  = sw_changed;
                rd_word[`FBEWM_ST_WARN]       = warning_output_bit;
                rd_word[`FBEWM_ST_MOTOR_STOP] = motor_stop;
                rd_word[`FBEWM_ST_BAD_SWITCH] = bad_switch;
                rd_word[`FBEWM_ST_SW_CHANGED] = sw_changed;
            end
            `FBEWM_REG_WARN_NOW: begin
                rd_word[7:0] = present_warning; // RULE12
            end
            `FBEWM_REG_HIST_CNT: begin
                rd_word[3:0] = hist_cnt;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // Read pipeline: one wait cycle, then data with waitrequest low
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_pending   <= 1'b0;
            rd_hist      <= 1'b0;
            rd_latch     <= 32'h00000000;
            hist_rd_hold <= 4'h0;
        end else if (rd_take) begin
            rd_pending   <= 1'b1;
            rd_hist      <= (avs_address[7:6] == `FBEWM_HIST_SEL) && (avs_address[5:2] < hist_cnt);
            rd_latch     <= rd_word;
            hist_rd_hold <= hist_rd_addr;
        end else begin
            rd_pending <= 1'b0;
        end
    end

    // Answer word: history byte from the memory's output register, else the latched word.
    // Limitation: a new warning that overwrites the slot just read changes the byte shown.
    always @* begin
        if (rd_hist) begin
            avs_readdata = {24'h000000, hist_q}; // RULE8
        end else begin
            avs_readdata = rd_latch;
        end
    end

endmodule // fbewm_monitor

`default_nettype wire

// >>> bench/fbewm_master_model.sv
// Behavioural fieldbus master station
`timescale 1ns/10ps
`default_nettype none
module fbewm_master_model (
    // Clock
    input  wire logic clk,
    // Bench commands
    input  wire logic cmd_stop,
    input  wire logic cmd_halt,
    // Conditions seen by the converter
    output var  logic link_stopped,
    output var  logic master_halted
);
    // Master reacts one scan late, as a real station does
    always @(posedge clk) begin
        link_stopped <= cmd_stop;
        master_halted <= cmd_halt;
    end
endmodule // fbewm_master_model
`default_nettype wire

// >>> bench/fbewm_monitor_assertions.sv
// Checker for the error and warning monitor
`timescale 1ns/10ps
`default_nettype none
module fbewm_chk (
    // Clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // Causes
    input wire logic       link_stopped,
    input wire logic       station_duplicate,
    input wire logic       link_fault,
    input wire logic       master_halted,
    input wire logic       motor_running,
    input wire logic       serial_error,
    input wire logic       serial_timeout,
    // Outputs
    input wire logic       link_run_led,
    input wire logic       motor_stop,
    input wire logic       warning_output_bit,
    input wire logic [7:0] present_warning
);
    // One clock domain for every check
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_warn_on; serial_error || serial_timeout |=> warning_output_bit; endproperty
    a_warn_on: assert property (p_warn_on) else $error("warning bit missing");
    property p_warn_off; !(serial_error || serial_timeout) |=> !warning_output_bit; endproperty
    a_warn_off: assert property (p_warn_off) else $error("warning bit stuck");
    property p_none; !(serial_error || serial_timeout) |=> present_warning == 8'h00; endproperty
    a_none: assert property (p_none) else $error("idle code not zero");
    property p_ser; $rose(serial_error) && !$rose(serial_timeout) |=> present_warning == 8'h84; endproperty
    a_ser: assert property (p_ser) else $error("serial error code wrong");
    property p_tmo; $rose(serial_timeout) |=> present_warning == 8'h85; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout code wrong");
    property p_fault; link_fault ##1 link_fault |-> motor_stop; endproperty
    a_fault: assert property (p_fault) else $error("motor runs on link error");
    property p_halt; (master_halted && motor_running) [*2] |-> motor_stop; endproperty
    a_halt: assert property (p_halt) else $error("motor runs on halt");
    property p_stop; link_stopped ##1 link_stopped |-> !link_run_led; endproperty
    a_stop: assert property (p_stop) else $error("run lamp on, link stopped");
    property p_dup; station_duplicate ##1 station_duplicate |-> !link_run_led; endproperty
    a_dup: assert property (p_dup) else $error("run lamp on, duplicate");
endmodule // fbewm_chk
bind fbewm_monitor fbewm_chk i_chk (.clk, .sys_rst, .link_stopped, .station_duplicate, .link_fault,
    .master_halted, .motor_running, .serial_error, .serial_timeout, .link_run_led, .motor_stop,
    .warning_output_bit, .present_warning);
`default_nettype wire

// >>> bench/tb_fieldbus_error_warning_monitor.sv
// Self-checking bench for the error and warning monitor
`timescale 1ns/10ps
`default_nettype none
module tb_fieldbus_error_warning_monitor;
    logic        clk, sys_rst, cmd_stop, cmd_halt, link_stopped, master_halted; // Clock, master
    logic [2:0]  baud_switch;   // Switches
    logic [6:0]  station_switch;
    logic        station_duplicate, link_fault, motor_running, serial_error, serial_timeout;
    logic        link_run_led, link_err_led, motor_stop, warning_output_bit;
    logic [7:0]  present_warning, avs_address;
    logic        avs_read, avs_write, avs_waitrequest, p;
    logic [7:0]  h0, h1;        // Two newest history codes expected
    logic [31:0] avs_writedata, avs_readdata;
    logic [31:0] exp_q[$];      // Expected read data, oldest first
    int          failures, compares, n, k;
    fbewm_master_model i_master (.clk, .cmd_stop, .cmd_halt, .link_stopped, .master_halted);
    // Short blink so a few half periods fit in the run
    fbewm_monitor #(.BLINK_CYCLES(4)) i_dut (.clk, .sys_rst, .baud_switch, .station_switch,
        .link_stopped, .station_duplicate, .link_fault, .master_halted, .motor_running,
        .serial_error, .serial_timeout, .link_run_led, .link_err_led, .motor_stop,
        .warning_output_bit, .present_warning, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest);
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Hold the request until waitrequest is low at a rising edge
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        // Flops update after this process reads, so the edge's own waitrequest is seen
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask
    // Settle: sample on the falling edge
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic boot(input logic [2:0] b, input logic [6:0] s);
        @(posedge clk);
        sys_rst <= 1'b1;
        baud_switch <= b;
        station_switch <= s;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        wt(3);
    endtask
    task automatic wrap_up();
        if (exp_q.size() != 0) failures++;
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Read data taken at the rising edge that sees waitrequest low
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            chk(avs_readdata, exp_q.pop_front());
    end
    // Watchdog well past the expected run
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    initial begin
        {sys_rst, cmd_stop, cmd_halt, station_duplicate, link_fault} = 5'h10;
        {motor_running, serial_error, serial_timeout, avs_read, avs_write} = 5'h00;
        {baud_switch, station_switch, avs_address, avs_writedata} = 50'h0;
        {failures, compares} = 64'h0;
        void'($urandom(32'hD494));
        boot(3'($urandom_range(4)), 7'($urandom_range(64, 1)));
        chk({link_run_led, link_err_led, motor_stop}, 3'h4);
        rd(8'h0C, 32'h0);
        rd(8'h20, 32'h0);
        // Each link condition in turn
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            cmd_stop <= (k == 0);
            link_fault <= (k == 1);
            cmd_halt <= (k == 2);
            station_duplicate <= (k == 3);
            motor_running <= 1'b1;
            wt(4);
            if (k == 0 || k == 3) chk(link_run_led, 1'b0);
            else chk(motor_stop, 1'b1);
        end
        @(posedge clk);
        {cmd_stop, link_fault, cmd_halt, station_duplicate} <= 4'h0;
        boot(3'h0, 7'h40);
        chk(link_run_led, 1'b1);
        @(posedge clk);
        serial_error <= 1'b1;
        wt(2);
        chk({warning_output_bit, motor_stop, present_warning}, 10'h284);
        rd(8'h08, 32'h84);
        @(posedge clk);
        serial_timeout <= 1'b1;
        wt(2);
        chk(present_warning, 8'h85);
        @(posedge clk);
        {serial_error, serial_timeout} <= 2'h0;
        wt(2);
        chk({warning_output_bit, present_warning}, 9'h000);
        h0 = 8'h85;
        h1 = 8'h84;
        n = 2 + $urandom_range(12, 6);
        for (k = 2; k < n; k++) begin
            @(posedge clk);
            p = $urandom_range(1);
            h1 = h0;
            h0 = p ? 8'h84 : 8'h85;
            serial_error <= p;
            serial_timeout <= !p;
            @(posedge clk);
            {serial_error, serial_timeout} <= 2'h0;
            wt(2);
        end
        rd(8'h0C, (n > 10) ? 32'hA : 32'(n));
        rd(8'h40, h0);
        rd(8'h44, h1);
        boot(3'h4, 7'h01);
        rd(8'h0C, 32'h0);
        // Both causes rise together: timeout is latest, both are logged
        @(posedge clk);
        {serial_error, serial_timeout} <= 2'h3;
        wt(3);
        chk(present_warning, 8'h85);
        rd(8'h0C, 32'h2);
        rd(8'h40, 32'h85);
        rd(8'h44, 32'h84);
        rd(8'h48, 32'h0);
        bus(1'b0, 8'h00, 32'h1);
        {serial_error, serial_timeout} <= 2'h0;
        wt(2);
        rd(8'h0C, 32'h0);
        // Out-of-range switch values
        for (k = 0; k < 3; k++) begin
            boot(k == 0 ? 3'h5 : 3'h4, k == 1 ? 7'h00 : (k == 2 ? 7'h41 : 7'h01));
            chk({link_run_led, link_err_led}, 2'h1);
        end
        boot(3'h2, 7'h10);
        @(posedge clk);
        baud_switch <= 3'h3;
        n = 0;
        p = link_err_led;
        repeat (24) begin
            @(negedge clk);
            if (link_err_led !== p) n++;
            p = link_err_led;
        end
        chk(n >= 4, 1'b1);
        wt(1);
        wrap_up();
    end
endmodule // tb_fieldbus_error_warning_monitor
`default_nettype wire
